// [qdl_channel_reg.sv]
// one channel: input register and converter register
`timescale 1ns/1ns
`default_nettype none
module qdl_channel_reg #(
	parameter int CODE_BITS = 8
) (
	input wire logic clk, // system clock
	input wire logic resetn, // synchronous reset, active low
	input wire logic zeroAll, // clear both levels, active high
	input wire logic loadAll, // converter follows input, active high
	input wire logic writeEn, // input register takes writeData
	input wire logic [CODE_BITS-1:0] writeData, // new code
	output logic [CODE_BITS-1:0] inputCode, // input register
	output logic [CODE_BITS-1:0] convCode // converter register
);
	logic [CODE_BITS-1:0] nxt_inputCode;

	// next input value, clear has priority over a write
	always_comb
	begin
		nxt_inputCode = inputCode;
		if (zeroAll)
			nxt_inputCode = qdl_pkg::CODE_ZERO;
		else if (writeEn)
			nxt_inputCode = writeData;
	end

	// input register
	always_ff @(posedge clk)
	begin
		if (!resetn)
			inputCode <= qdl_pkg::CODE_ZERO;
		else
			inputCode <= nxt_inputCode;
	end

	// converter register, transparent while load is held
	always_ff @(posedge clk)
	begin
		if (!resetn)
			convCode <= qdl_pkg::CODE_ZERO;
		else if (zeroAll)
			convCode <= qdl_pkg::CODE_ZERO;
		else if (loadAll)
			convCode <= nxt_inputCode;
	end
endmodule // qdl_channel_reg
`default_nettype wire

// [qdl_host_model.sv]
// behavioural serial host for the quad load control
`timescale 1ns/1ns
`default_nettype none
module qdl_host_model (
	input wire logic go, // start one frame
	input wire logic [15:0] txWord, // bits, right aligned
	input wire logic [4:0] txBits, // bit count
	output logic chipSelectN, // select, active low
	output logic shiftClock, // link clock, idle low
	output logic serialIn, // data line
	output logic busy // frame running
);
	// ************
	// frame generator
	// ************
	initial
	begin
		chipSelectN = 1'b1;
		shiftClock = 1'b0;
		serialIn = 1'b1;
		busy = 1'b0;
		forever
		begin
			@(posedge go);
			busy = 1'b1;
			#33 chipSelectN = 1'b0;
			// top bit first, data set while clock low
			for (int i = int'(txBits) - 1; i >= 0; i--)
			begin
				serialIn = txWord[i];
				#80 shiftClock = 1'b1;
				#80 shiftClock = 1'b0;
			end
			#80 chipSelectN = 1'b1;
			serialIn = ~serialIn; // no stale bit on a released line
			#200 busy = 1'b0;
		end
	end
endmodule // qdl_host_model
`default_nettype wire

// [qdl_load_control.sv]
// load control of a four-channel 8-bit converter, serial and parallel
`timescale 1ns/1ns
`default_nettype none
module qdl_load_control (
	input wire logic clk, // system clock, 50 MHz
	input wire logic resetn, // synchronous reset, active low
	input wire logic parallelMode, // 1 selects the parallel front end
	input wire logic chipSelectN, // serial chip select, active low
	input wire logic shiftClock, // serial shift clock
	input wire logic serialInOrFloatOff, // serial data pin
	input wire logic writeN, // parallel write strobe, active low
	input wire logic [7:0] busBits, // parallel data, bit 7 on top
	input wire logic channelSelectHi, // parallel address bit 1
	input wire logic channelSelectLoOrFloatOff, // parallel address bit 0
	input wire logic floatPowerDown, // float detect flag, active high
	input wire logic loadAllN, // load strobe, active low
	input wire logic zeroAllN, // clear, active low
	output logic [7:0] channelOutputA, // converter code channel A
	output logic [7:0] channelOutputB, // converter code channel B
	output logic [7:0] channelOutputC, // converter code channel C
	output logic [7:0] channelOutputD, // converter code channel D
	output logic [3:0] channelOutputOpen, // 1 = channel output open
	output logic [3:0] commandOff, // commanded power down per channel
	output logic [11:0] shiftWord // serial shift register contents
);
	// ************************************************************
	// pin sampling
	// ************************************************************
	logic [qdl_pkg::PIN_COUNT-1:0] pinRaw;
	logic [qdl_pkg::PIN_COUNT-1:0] pinLvl;
	logic modeLvl;
	logic csnLvl;
	logic sclkLvl;
	logic sdiLvl;
	logic wrnLvl;
	logic [7:0] busLvl;
	logic addrHiLvl;
	logic addrLoLvl;
	logic floatLvl;
	logic ldacnLvl;
	logic clrnLvl;

	// pin vector order matches the reset image in the package
	assign pinRaw = {modeLvlPin(parallelMode), floatPowerDown,
		channelSelectHi, channelSelectLoOrFloatOff, busBits,
		zeroAllN, loadAllN, writeN, serialInOrFloatOff,
		shiftClock, chipSelectN};

	// identity helper keeping the vector readable
	function automatic logic modeLvlPin(input logic v);
		modeLvlPin = v;
	endfunction

	qdl_pin_sync #(
		.WIDTH(qdl_pkg::PIN_COUNT),
		.RESET_VAL(qdl_pkg::PIN_RESET)
	) u_pins (
		.clk(clk),
		.resetn(resetn),
		.pinIn(pinRaw),
		.pinLevel(pinLvl)
	);

	// unpack the filtered levels
	assign csnLvl = pinLvl[0];
	assign sclkLvl = pinLvl[1];
	assign sdiLvl = pinLvl[2];
	assign wrnLvl = pinLvl[3];
	assign ldacnLvl = pinLvl[4];
	assign clrnLvl = pinLvl[5];
	assign busLvl = pinLvl[13:6];
	assign addrLoLvl = pinLvl[14];
	assign addrHiLvl = pinLvl[15];
	assign floatLvl = pinLvl[16];
	assign modeLvl = pinLvl[17];

	// ************************************************************
	// edge detection on filtered levels
	// ************************************************************
	logic sclkPrev_ff;
	logic csnPrev_ff;
	logic sclkRise;
	logic csnRise;

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			sclkPrev_ff <= 1'b0;
			csnPrev_ff <= 1'b1;
		end
		else
		begin
			sclkPrev_ff <= sclkLvl;
			csnPrev_ff <= csnLvl;
		end
	end

	assign sclkRise = sclkLvl & ~sclkPrev_ff;
	assign csnRise = csnLvl & ~csnPrev_ff & ~modeLvl;

	// ************************************************************
	// serial shift register
	// ************************************************************
	logic [11:0] shift_ff;
	logic [11:0] nxt_shift;

	// shift top bit first; older bits fall off the top
	always_comb
	begin
		nxt_shift = shift_ff;
		if (!modeLvl && !csnLvl && sclkRise)
			nxt_shift = {shift_ff[10:0], sdiLvl};
	end

	// the clear pin does not reach this register
	always_ff @(posedge clk)
	begin
		if (!resetn)
			shift_ff <= qdl_pkg::SHIFT_RESET;
		else
			shift_ff <= nxt_shift;
	end

	assign shiftWord = shift_ff;

	// ************************************************************
	// word decode
	// ************************************************************
	logic [1:0] serAddr;
	logic [7:0] serData;
	logic serAllOff;
	logic serSelOff;

	// only the last twelve bits are looked at
	assign serAllOff = shift_ff[qdl_pkg::POS_ALL_OFF];
	assign serSelOff = shift_ff[qdl_pkg::POS_SEL_OFF];
	assign serAddr = {shift_ff[qdl_pkg::POS_ADDR_HI],
		shift_ff[qdl_pkg::POS_ADDR_LO]};
	assign serData = shift_ff[qdl_pkg::POS_DATA_TOP:0];

	// ************************************************************
	// write selection for both front ends
	// ************************************************************
	logic [1:0] wrAddr;
	logic [7:0] wrData;
	logic wrAny;
	logic [3:0] wrSel;

	// parallel writes are held off while the float detect flag is high
	always_comb
	begin
		wrAddr = serAddr;
		wrData = serData;
		wrAny = csnRise;
		if (modeLvl)
		begin
			wrAddr = {addrHiLvl, addrLoLvl};
			wrData = busLvl;
			wrAny = ~wrnLvl & ~floatLvl;
		end
	end

	// address decode, 00 selects A up to 11 for D
	always_comb
	begin
		wrSel = 4'h0;
		case (wrAddr)
			qdl_pkg::CH_A: wrSel = 4'h1;
			qdl_pkg::CH_B: wrSel = 4'h2;
			qdl_pkg::CH_C: wrSel = 4'h4;
			qdl_pkg::CH_D: wrSel = 4'h8;
			default: wrSel = 4'h0;
		endcase
		if (!wrAny)
			wrSel = 4'h0;
	end

	// ************************************************************
	// channel registers
	// ************************************************************
	logic [7:0] convCode [qdl_pkg::CHANNELS];

	genvar ch;
	generate
		for (ch = 0; ch < qdl_pkg::CHANNELS; ch++)
		begin : g_chan
			qdl_channel_reg #(
				.CODE_BITS(qdl_pkg::CODE_BITS)
			) u_chan (
				.clk(clk),
				.resetn(resetn),
				.zeroAll(~clrnLvl),
				.loadAll(~ldacnLvl),
				.writeEn(wrSel[ch]),
				.writeData(wrData),
				.inputCode(),
				.convCode(convCode[ch])
			);
		end
	endgenerate

	// converter codes stay put through any power down
	assign channelOutputA = convCode[0];
	assign channelOutputB = convCode[1];
	assign channelOutputC = convCode[2];
	assign channelOutputD = convCode[3];

	// ************************************************************
	// commanded power down
	// ************************************************************
	logic [3:0] off_ff;
	logic [3:0] nxt_off;

	// each accepted word sets the whole power-down pattern anew
	always_comb
	begin
		nxt_off = off_ff;
		if (csnRise)
		begin
			if (!serAllOff)
				nxt_off = 4'hf;
			else if (!serSelOff)
				nxt_off = wrSel;
			else
				nxt_off = qdl_pkg::OFF_RESET;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			off_ff <= qdl_pkg::OFF_RESET;
		else
			off_ff <= nxt_off;
	end

	assign commandOff = off_ff;

	// ************************************************************
	// output drive state
	// ************************************************************
	logic [3:0] open_ff;

	// floating pin opens all outputs, command bits open some
	always_ff @(posedge clk)
	begin
		if (!resetn)
			open_ff <= qdl_pkg::OFF_RESET;
		else
			open_ff <= off_ff | {4{floatLvl}};
	end

	assign channelOutputOpen = open_ff;
endmodule // qdl_load_control
`default_nettype wire

// [qdl_load_control_assertions.sv]
// port checker of the quad load control
`timescale 1ns/1ns
`default_nettype none
module qdl_load_control_assertions (
	input wire logic clk, // clock
	input wire logic resetn, // reset, active low
	input wire logic chipSelectN, // select
	input wire logic floatPowerDown, // float flag
	input wire logic loadAllN, // load strobe
	input wire logic zeroAllN, // clear
	input wire logic [7:0] channelOutputA, // code A
	input wire logic [7:0] channelOutputB, // code B
	input wire logic [7:0] channelOutputC, // code C
	input wire logic [7:0] channelOutputD, // code D
	input wire logic [3:0] channelOutputOpen, // open flags
	input wire logic [3:0] commandOff, // commanded off
	input wire logic [11:0] shiftWord // shift register
);
	// ************
	// port relations
	// ************
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire logic [31:0] codes = {channelOutputD, channelOutputC,
		channelOutputB, channelOutputA};
	chk_clear_zero: assert property (
		!zeroAllN [*8] |-> codes == 32'h0)
		else $error("codes not zero under clear");
	chk_shift_blocked: assert property (
		chipSelectN [*8] |=> $stable(shiftWord))
		else $error("shift moved while deselected");
	chk_shift_msb: assert property ($changed(shiftWord) |->
		shiftWord[11:1] == $past(shiftWord[10:0]))
		else $error("shift not one bit");
	chk_float_open: assert property (floatPowerDown [*8] |->
		channelOutputOpen == 4'hf)
		else $error("float did not open outputs");
	chk_open_follow: assert property (!floatPowerDown [*8] |->
		channelOutputOpen == $past(commandOff))
		else $error("open flags differ from command");
	chk_load_hold: assert property ((loadAllN && zeroAllN) [*8] |=>
		$stable(codes))
		else $error("codes moved without load");
	chk_cmd_hold: assert property (
		chipSelectN [*8] |=> $stable(commandOff))
		else $error("command moved without select");
	chk_reset_zero: assert property ($rose(resetn) |->
		codes == 32'h0 && commandOff == 4'h0)
		else $error("reset left state");
endmodule // qdl_load_control_assertions
bind qdl_load_control qdl_load_control_assertions chk_i (.*);
`default_nettype wire

// [qdl_load_control_bench.sv]
// self-checking bench of the quad load control
`timescale 1ns/1ns
`default_nettype none
module qdl_load_control_bench;
	// ************
	// signals and parts
	// ************
	logic clk, resetn, parallelMode, writeN, channelSelectHi, go;
	logic channelSelectLoOrFloatOff, floatPowerDown, loadAllN, zeroAllN;
	logic [7:0] busBits, channelOutputA, channelOutputB;
	logic [7:0] channelOutputC, channelOutputD;
	logic [3:0] channelOutputOpen, commandOff;
	logic [11:0] shiftWord;
	logic [15:0] txWord;
	logic [4:0] txBits;
	wire logic chipSelectN, shiftClock, serialInOrFloatOff, hostBusy;
	wire logic [31:0] codes = {channelOutputD, channelOutputC,
		channelOutputB, channelOutputA};
	int err_total, n_checks, i;
	typedef struct {logic [11:0] w; int ch; logic [7:0] c;
		logic [3:0] o;} qdl_row_t;
	qdl_row_t rows [7] = '{'{12'hc5a, 0, 8'h5a, 4'h0},
		'{12'hd3c, 1, 8'h3c, 4'h0}, '{12'h2e7, 2, 8'he7, 4'hf},
		'{12'h781, 3, 8'h81, 4'hf}, '{12'hb99, 3, 8'h99, 4'h8},
		'{12'ha12, 2, 8'h12, 4'h4}, '{12'hcff, 0, 8'hff, 4'h0}};
	qdl_load_control dut (.*);
	qdl_host_model host (.go(go), .txWord(txWord), .txBits(txBits),
		.chipSelectN(chipSelectN), .shiftClock(shiftClock),
		.serialIn(serialInOrFloatOff), .busy(hostBusy));
	// ************
	// helpers
	// ************
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic send(logic [15:0] w, logic [4:0] n);
		txWord = w;
		txBits = n;
		go = 1'b1;
		tick(1);
		go = 1'b0;
		for (int k = 0; k < 400 && hostBusy; k++) tick(1);
		chk("host done", 32'h0, 32'(hostBusy));
		tick(4);
	endtask
	task automatic pwrite(logic [1:0] a, logic [7:0] d);
		{channelSelectHi, channelSelectLoOrFloatOff} = a;
		busBits = d;
		tick(5);
		writeN = 1'b0;
		tick(8);
		writeN = 1'b1;
		tick(6);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// clock and watchdog
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial
	begin
		#300000;
		err_total++;
		wrap_up;
	end
	// ************
	// main sequence
	// ************
	initial
	begin
		{resetn, parallelMode, channelSelectHi, go} = 4'h0;
		{channelSelectLoOrFloatOff, floatPowerDown} = 2'h0;
		{writeN, loadAllN, zeroAllN} = 3'h7;
		busBits = 8'h00;
		txWord = 16'h0000;
		txBits = 5'h0c;
		err_total = 0;
		n_checks = 0;
		tick(16);
		resetn = 1'b1;
		tick(2);
		chk("reset codes", 32'h0, codes);
		loadAllN = 1'b0;
		tick(8);
		for (i = 0; i < 7; i++)
		begin
			send({4'h0, rows[i].w}, 5'h0c);
			chk("code", 32'(rows[i].c), 32'(codes[8*rows[i].ch +: 8]));
			chk("off", 32'(rows[i].o), 32'(commandOff));
			chk("open", 32'(rows[i].o), 32'(channelOutputOpen));
			chk("shift", 32'(rows[i].w), 32'(shiftWord));
		end
		$display("test table done");
		send(16'hfd42, 5'h10);
		chk("long word", 32'h42, 32'(channelOutputB));
		loadAllN = 1'b1;
		tick(8);
		send(16'h0c11, 5'h0c);
		chk("held", 32'hff, 32'(channelOutputA));
		loadAllN = 1'b0;
		tick(8);
		chk("loaded", 32'h11, 32'(channelOutputA));
		zeroAllN = 1'b0;
		tick(10);
		chk("cleared", 32'h0, codes);
		chk("shift kept", 32'hc11, 32'(shiftWord));
		zeroAllN = 1'b1;
		parallelMode = 1'b1;
		tick(8);
		for (i = 0; i < 4; i++) pwrite(i[1:0], 8'h80 >> i);
		chk("parallel", 32'h10204080, codes);
		floatPowerDown = 1'b1;
		tick(8);
		pwrite(2'h0, 8'h55);
		chk("float open", 32'hf, 32'(channelOutputOpen));
		chk("float kept", 32'h10204080, codes);
		floatPowerDown = 1'b0;
		tick(8);
		chk("wake", 32'h0, 32'(channelOutputOpen));
		resetn = 1'b0;
		tick(5);
		resetn = 1'b1;
		tick(2);
		chk("second reset", 32'h0, codes);
		$display("test hand cases done");
		wrap_up;
	end
endmodule // qdl_load_control_bench
`default_nettype wire

// [qdl_pin_sync.sv]
// three-stage pin sampler with agreement filter
`timescale 1ns/1ns
`default_nettype none
module qdl_pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk, // system clock
	input wire logic resetn, // synchronous reset, active low
	input wire logic [WIDTH-1:0] pinIn, // raw pins from outside
	output logic [WIDTH-1:0] pinLevel // filtered level
);
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] stage3_ff;

	// ************************************************************
	// sampling chain, first stage feeds only the second
	// ************************************************************
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			stage1_ff <= RESET_VAL;
			stage2_ff <= RESET_VAL;
			stage3_ff <= RESET_VAL;
		end
		else
		begin
			stage1_ff <= pinIn;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
		end
	end

	// a bit changes only once stages two and three agree
	always_ff @(posedge clk)
	begin
		if (!resetn)
			pinLevel <= RESET_VAL;
		else
			for (int i = 0; i < WIDTH; i++)
				if (stage2_ff[i] == stage3_ff[i])
					pinLevel[i] <= stage3_ff[i];
	end
endmodule // qdl_pin_sync
`default_nettype wire

// [qdl_pkg.sv]
// shared constants of the quad converter load control
package qdl_pkg;
	// ************************************************************
	// word format and channel map
	// ************************************************************
	localparam int CHANNELS = 4;
	localparam int CODE_BITS = 8;
	localparam int WORD_BITS = 12;
	localparam int POS_ALL_OFF = 11;
	localparam int POS_SEL_OFF = 10;
	localparam int POS_ADDR_HI = 9;
	localparam int POS_ADDR_LO = 8;
	localparam int POS_DATA_TOP = 7;
	localparam logic [1:0] CH_A = 2'h0;
	localparam logic [1:0] CH_B = 2'h1;
	localparam logic [1:0] CH_C = 2'h2;
	localparam logic [1:0] CH_D = 2'h3;
	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] CODE_ZERO = 8'h00;
	localparam logic [11:0] SHIFT_RESET = 12'h000;
	localparam logic [3:0] OFF_RESET = 4'h0;
	// pin sampler reset image, bit order as in the top-level pin vector
	localparam int PIN_COUNT = 18;
	// idle levels: select, write, load and clear high, all else low
	localparam logic [17:0] PIN_RESET = 18'h00039;
endpackage
